// >>> hw/lfs_defines.vh
// constants of the lubricator fault and status block
// assumes inclusion by bare name from the design files
`ifndef LFS_DEFINES_VH
`define LFS_DEFINES_VH
// register byte offsets
`define LFS_REG_CTRL     5'h00
`define LFS_REG_INTERVAL 5'h04
`define LFS_REG_ELAPSED  5'h08
`define LFS_REG_CAPACITY 5'h0C
`define LFS_REG_STROKES  5'h10
`define LFS_REG_STATUS   5'h14
// control fields and reset values
`define LFS_CTRL_MODE_LO 0
`define LFS_CTRL_LARGE   2
`define LFS_CTRL_OFF     3
`define LFS_MODE_HOUR    2'h0
`define LFS_MODE_EMPTY   2'h1
`define LFS_MODE_PULSE   2'h2
`define LFS_INTERVAL_RST 16'h0E10
`define LFS_CAPACITY_RST 16'h0320
// fill warning thresholds in percent
`define LFS_PCT_STD      7'h12
`define LFS_PCT_LARGE    7'h1C
`define LFS_PCT_SCALE    7'h64
// overpressure limit in bar
`define LFS_PRESS_LIMIT  7'h46
// timing; LFS_MS_NS and LFS_CLK_NS in ns, the rest in ms
`define LFS_MS_NS        1000000
`define LFS_CLK_NS       10
`define LFS_HALF_WAVE_MS 11'h3E8
`define LFS_SEC_MS       11'h3E8
`define LFS_SELFCHK_MS   11'h1F4
// command pulse windows in ms (tolerance 25 ms)
`define LFS_CMD_STROKE_LO 11'h04B
`define LFS_CMD_STROKE_HI 11'h07D
`define LFS_CMD_FILL_LO   11'h36B
`define LFS_CMD_FILL_HI   11'h39D
`define LFS_CMD_CANCEL_LO 11'h3CF
`define LFS_CMD_CANCEL_HI 11'h401
`define LFS_CMD_STAT_LO   11'h627
`define LFS_CMD_STAT_HI   11'h659
`define LFS_CMD_ACK_LO    11'h68B
`define LFS_CMD_ACK_HI    11'h6BD
`define LFS_FILL_STROKES  6'h28
// display screens
`define LFS_SCR_IDLE     2'h0
`define LFS_SCR_FAULT    2'h1
`define LFS_SCR_FILL     2'h2
`define LFS_SCR_CHECK    2'h3
`endif

// >>> hw/lfs_divider.v
// restoring divider used to turn remaining strokes into a fill percent
// assumes start is only raised while busy is low
`timescale 1ns/1ns
`default_nettype none
module lfs_divider #(
  parameter W = 24
) (
  input  wire         mclk_in,
  input  wire         rst_in,
  input  wire         ce_in,
  input  wire         start_in,
  input  wire [W-1:0] num_in,
  input  wire [W-1:0] den_in,
  output reg          busy_out,
  output reg  [W-1:0] quot_out
);
  reg [W-1:0] rem;
  reg [W-1:0] q;
  reg [W-1:0] den;
  reg [5:0]   cnt;
  wire [W:0]  trial = {rem, q[W-1]} - {1'b0, den};
  // one quotient bit per cycle; latency W cycles is fine at ms rates
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rem      <= {W{1'b0}};
      q        <= {W{1'b0}};
      den      <= {W{1'b0}};
      cnt      <= 6'h00;
      busy_out <= 1'b0;
      quot_out <= {W{1'b0}};
    end else if (ce_in) begin
      if (start_in && !busy_out) begin
        rem      <= {W{1'b0}};
        q        <= num_in;
        den      <= den_in;
        cnt      <= W[5:0];
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (!trial[W]) begin
          rem <= trial[W-1:0];
          q   <= {q[W-2:0], 1'b1};
        end else begin
          rem <= {rem[W-2:0], q[W-1]};
          q   <= {q[W-2:0], 1'b0};
        end
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy_out <= 1'b0;
        end
      end else begin
        quot_out <= q;
      end
    end
  end
endmodule // lfs_divider
`default_nettype wire

// >>> hw/lfs_top.v
// fault supervision, fill warning, status line and command decode
// assumes all inputs synchronous to mclk_in; power cycle maps to rst_in
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "lfs_defines.vh"
module lfs_top #(
  parameter MS_CYCLES = (`LFS_MS_NS + `LFS_CLK_NS - 1) / `LFS_CLK_NS
) (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire        ce_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire [6:0]  pressure_bar_in,
  input  wire        supply_bad_in,
  input  wire        internal_bad_in,
  input  wire        stroke_done_in,
  input  wire        local_ack_in,
  input  wire        selftest_in,
  input  wire        cartridge_new_in,
  input  wire        cmd_in,
  output reg         status_out,
  output reg         pump_enable_out,
  output reg         stroke_req_out,
  output reg  [1:0]  screen_out,
  output reg  [2:0]  fault_num_out,
  output reg  [6:0]  fill_pct_out,
  output reg         low_fill_out
);
  // ***************************************************************
  // register file
  // ***************************************************************
  reg [1:0]  mode;
  reg        large_cart;
  reg        op_off;
  reg [15:0] interval_s;
  reg [15:0] elapsed_s;
  reg [15:0] capacity;
  reg [15:0] strokes;
  reg        empty_cartridge_notice;
  reg        overpressure_fault;
  reg        supply_voltage_fault;
  reg        internal_device_fault;
  reg        bad_cmd;
  reg        selfcheck;
  wire       pulse_mode = (mode == `LFS_MODE_PULSE);
  wire       req = avs_read_in | avs_write_in;
  wire       wr_ok = avs_write_in && !avs_waitrequest_out;
  wire       ctrl_wr = wr_ok && (avs_address_in == `LFS_REG_CTRL);
  wire       elap_wr = wr_ok && (avs_address_in == `LFS_REG_ELAPSED);
  reg [31:0] next_readdata;
  wire [15:0] div_q;
  // read mux; unmapped offsets read as zero
  always @* begin
    next_readdata = 32'h0000_0000;
    case (avs_address_in)
      `LFS_REG_CTRL:     next_readdata = {28'h0, op_off, large_cart, mode};
      `LFS_REG_INTERVAL: next_readdata = {16'h0, interval_s};
      `LFS_REG_ELAPSED:  next_readdata = {16'h0, elapsed_s};
      `LFS_REG_CAPACITY: next_readdata = {16'h0, capacity};
      `LFS_REG_STROKES:  next_readdata = {16'h0, strokes};
      `LFS_REG_STATUS:   next_readdata = {17'h0, fill_pct_out, 1'b0, selfcheck,
                                          bad_cmd, low_fill_out,
                                          internal_device_fault,
                                          supply_voltage_fault,
                                          overpressure_fault,
                                          empty_cartridge_notice};
      default:           next_readdata = 32'h0000_0000;
    endcase
  end
  // one wait state per access, then the transfer completes
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      interval_s          <= `LFS_INTERVAL_RST;
      capacity            <= `LFS_CAPACITY_RST;
    end else if (ce_in) begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
      if (req && avs_waitrequest_out) begin
        avs_readdata_out <= next_readdata;
      end
      if (wr_ok && avs_address_in == `LFS_REG_INTERVAL) begin
        interval_s <= avs_writedata_in[15:0];
      end
      if (wr_ok && avs_address_in == `LFS_REG_CAPACITY) begin
        capacity <= avs_writedata_in[15:0];
      end
    end
  end
  // ***************************************************************
  // timebase and self-check
  // ***************************************************************
  reg [16:0] ms_div;
  reg        ms_tick;
  reg [10:0] sec_ms;
  reg [10:0] wave_ms;
  reg        wave;
  reg [10:0] chk_ms;
  wire       sec_tick = ms_tick && (sec_ms == `LFS_SEC_MS - 11'h001);
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ms_div  <= 17'h00000;
      ms_tick <= 1'b0;
      sec_ms  <= 11'h000;
      wave_ms <= 11'h000;
      wave    <= 1'b1;
      chk_ms  <= 11'h000;
      selfcheck <= 1'b1;
    end else if (ce_in) begin
      ms_tick <= (ms_div == MS_CYCLES[16:0] - 17'h00001);
      ms_div  <= (ms_div == MS_CYCLES[16:0] - 17'h00001) ? 17'h00000 : ms_div + 17'h00001;
      if (ms_tick) begin
        sec_ms <= sec_tick ? 11'h000 : sec_ms + 11'h001;
        // 0.5 Hz with even halves
        if (wave_ms == `LFS_HALF_WAVE_MS - 11'h001) begin
          wave_ms <= 11'h000;
          wave    <= ~wave;
        end else begin
          wave_ms <= wave_ms + 11'h001;
        end
        // self-check window after power-up or a self-test request
        if (selfcheck) begin
          chk_ms <= chk_ms + 11'h001;
          if (chk_ms == `LFS_SELFCHK_MS - 11'h001) begin
            selfcheck <= 1'b0;
          end
        end
      end
      if (selftest_in) begin
        selfcheck <= 1'b1;
        chk_ms    <= 11'h000;
      end
    end
  end
  // ***************************************************************
  // command pulse decode
  // ***************************************************************
  reg [10:0] hi_ms;
  reg        cmd_d;
  reg        too_long;
  reg        cmd_stroke;
  reg        cmd_fill;
  reg        cmd_cancel;
  reg        cmd_ack;
  wire       cmd_fall = cmd_d && !cmd_in;
  // width classed on the falling edge; overlong highs flagged at once
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hi_ms <= 11'h000;
      cmd_d <= 1'b0;
      too_long <= 1'b0;
      cmd_stroke <= 1'b0;
      cmd_fill <= 1'b0;
      cmd_cancel <= 1'b0;
      cmd_ack <= 1'b0;
      bad_cmd <= 1'b0;
    end else if (ce_in) begin
      cmd_d <= cmd_in;
      cmd_stroke <= 1'b0;
      cmd_fill <= 1'b0;
      cmd_cancel <= 1'b0;
      cmd_ack <= 1'b0;
      if (!pulse_mode) begin
        hi_ms    <= 11'h000;
        too_long <= 1'b0;
      end else if (cmd_in) begin
        if (ms_tick && !too_long) begin
          hi_ms <= hi_ms + 11'h001;
        end
        if (hi_ms > `LFS_CMD_ACK_HI) begin
          too_long <= 1'b1;
          bad_cmd  <= 1'b1;
        end
      end else if (cmd_fall) begin
        hi_ms    <= 11'h000;
        too_long <= 1'b0;
        if (hi_ms >= `LFS_CMD_STROKE_LO && hi_ms <= `LFS_CMD_STROKE_HI) begin
          cmd_stroke <= 1'b1;
          bad_cmd    <= 1'b0;
        end else if (hi_ms >= `LFS_CMD_FILL_LO && hi_ms <= `LFS_CMD_FILL_HI) begin
          cmd_fill <= 1'b1;
          bad_cmd  <= 1'b0;
        end else if (hi_ms >= `LFS_CMD_CANCEL_LO && hi_ms <= `LFS_CMD_CANCEL_HI) begin
          cmd_cancel <= 1'b1;
          bad_cmd    <= 1'b0;
        end else if (hi_ms >= `LFS_CMD_STAT_LO && hi_ms <= `LFS_CMD_STAT_HI) begin
          bad_cmd <= 1'b0;
        end else if (hi_ms >= `LFS_CMD_ACK_LO && hi_ms <= `LFS_CMD_ACK_HI) begin
          cmd_ack <= 1'b1;
          bad_cmd <= 1'b0;
        end else begin
          bad_cmd <= 1'b1;
        end
      end
    end
  end
  // ***************************************************************
  // faults and acknowledge
  // ***************************************************************
  wire ack = pulse_mode ? cmd_ack : local_ack_in;
  wire over_now = pressure_bar_in > `LFS_PRESS_LIMIT;
  wire hard_fault = overpressure_fault | supply_voltage_fault | internal_device_fault;
  wire empty_now = (strokes >= capacity);
  // a condition still present re-sets its fault flag over any clear; the empty notice drops while cartridge_new_in is high
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      overpressure_fault     <= 1'b0;
      supply_voltage_fault   <= 1'b0;
      internal_device_fault  <= 1'b0;
      empty_cartridge_notice <= 1'b0;
    end else if (ce_in) begin
      overpressure_fault <= over_now | (overpressure_fault & ~selftest_in);
      supply_voltage_fault  <= supply_bad_in | (supply_voltage_fault & ~ack);
      internal_device_fault <= internal_bad_in | (internal_device_fault & ~ack);
      empty_cartridge_notice <= empty_now & ~cartridge_new_in;
    end
  end
  // ***************************************************************
  // delivery scheduling and stroke count
  // ***************************************************************
  reg        in_flight;
  reg [5:0]  fill_left;
  wire       can_pump = !hard_fault && !empty_cartridge_notice && !op_off
                        && !selfcheck;
  wire       due = !pulse_mode && sec_tick && (elapsed_s + 16'h0001 >= interval_s);
  wire       want = pulse_mode ? (cmd_stroke || fill_left != 6'h00) : due;
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode <= `LFS_MODE_HOUR;
      large_cart <= 1'b0;
      op_off <= 1'b0;
      elapsed_s <= 16'h0000;
      strokes <= 16'h0000;
      in_flight <= 1'b0;
      fill_left <= 6'h00;
      stroke_req_out <= 1'b0;
      pump_enable_out <= 1'b0;
    end else if (ce_in) begin
      if (ctrl_wr) begin
        mode       <= avs_writedata_in[1:0];
        large_cart <= avs_writedata_in[`LFS_CTRL_LARGE];
        op_off     <= avs_writedata_in[`LFS_CTRL_OFF];
      end
      // elapsed time survives power loss by software restore
      if (elap_wr) begin
        elapsed_s <= avs_writedata_in[15:0];
      end else if (due) begin
        elapsed_s <= 16'h0000;
      end else if (!pulse_mode && sec_tick && can_pump) begin
        elapsed_s <= elapsed_s + 16'h0001;
      end
      if (cmd_fill) begin
        fill_left <= `LFS_FILL_STROKES;
      end else if (cmd_cancel || !can_pump) begin
        fill_left <= 6'h00;
      end else if (stroke_done_in && fill_left != 6'h00) begin
        fill_left <= fill_left - 6'h01;
      end
      stroke_req_out <= want && can_pump && !in_flight && !stroke_req_out;
      if (stroke_req_out) begin
        in_flight <= 1'b1;
      end else if (stroke_done_in) begin
        in_flight <= 1'b0;
      end
      if (cartridge_new_in) begin
        strokes <= 16'h0000;
      end else if (stroke_done_in) begin
        strokes <= strokes + 16'h0001;
      end
      pump_enable_out <= can_pump;
    end
  end
  // ***************************************************************
  // fill level, status line and display
  // ***************************************************************
  wire [15:0] remain = empty_now ? 16'h0000 : capacity - strokes;
  wire [6:0]  pct = large_cart ? `LFS_PCT_LARGE : `LFS_PCT_STD;
  wire [23:0] rem_x100 = remain * `LFS_PCT_SCALE;
  wire [23:0] cap_xpct = capacity * pct;
  wire        div_busy;
  wire [23:0] div_quot;
  lfs_divider #(
    .W (24)
  ) u_div (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .start_in (ms_tick && !div_busy),
    .num_in   (rem_x100),
    .den_in   ({8'h00, capacity}),
    .busy_out (div_busy),
    .quot_out (div_quot)
  );
  assign div_q = div_quot[15:0];
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      low_fill_out  <= 1'b0;
      fill_pct_out  <= 7'h00;
      status_out    <= 1'b1;
      screen_out    <= `LFS_SCR_CHECK;
      fault_num_out <= 3'h0;
    end else if (ce_in) begin
      low_fill_out <= (rem_x100 < cap_xpct);
      fill_pct_out <= (div_q > 16'h0064) ? `LFS_PCT_SCALE : div_q[6:0];
      // fault low outranks empty wave, otherwise high
      if (hard_fault) begin
        status_out <= 1'b0;
      end else if (empty_cartridge_notice && !pulse_mode && !op_off) begin
        status_out <= wave;
      end else begin
        status_out <= 1'b1;
      end
      if (internal_device_fault) begin
        fault_num_out <= 3'h4;
      end else if (supply_voltage_fault) begin
        fault_num_out <= 3'h3;
      end else if (overpressure_fault) begin
        fault_num_out <= 3'h2;
      end else if (empty_cartridge_notice) begin
        fault_num_out <= 3'h1;
      end else begin
        fault_num_out <= 3'h0;
      end
      if (hard_fault || empty_cartridge_notice) begin
        screen_out <= `LFS_SCR_FAULT;
      end else if (selfcheck) begin
        screen_out <= `LFS_SCR_CHECK;
      end else if (low_fill_out) begin
        screen_out <= `LFS_SCR_FILL;
      end else begin
        screen_out <= `LFS_SCR_IDLE;
      end
    end
  end
endmodule // lfs_top
`default_nettype wire

// >>> verification/lfs_top_asserts.sv
// checker: port-level properties of the fault and status block
// assumes one clock domain; bound to lfs_top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module lfs_top_asserts #(
  parameter MS_CYCLES = 10
) (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic [6:0] pressure_bar_in,
  input wire logic       supply_bad_in,
  input wire logic       status_out,
  input wire logic       pump_enable_out,
  input wire logic       stroke_req_out,
  input wire logic [1:0] screen_out,
  input wire logic [2:0] fault_num_out,
  input wire logic [6:0] fill_pct_out,
  input wire logic       low_fill_out
);
  localparam int HALF = 1000 * MS_CYCLES;
  int   run;   // cycles since the status line last changed
  logic prev;  // status line one cycle ago
  logic seen;  // one change already seen under the empty notice
  logic armed; // halves from here on are full length
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // half-wave timer; the first half after entry may be cut short, so two changes arm it
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      run   <= 0;
      prev  <= 1'b1;
      seen  <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev  <= status_out;
      run   <= (status_out != prev) ? 0 : run + 1;
      seen  <= (fault_num_out == 3'h1) && (seen || status_out != prev);
      armed <= (fault_num_out == 3'h1) && (armed || (seen && status_out != prev));
    end
  end
  chk_fault_low: assert property (supply_bad_in [*3] |-> ##[1:4] (!status_out && !pump_enable_out))
    else $error("status or pump not low under supply fault");
  chk_press_stop: assert property ((pressure_bar_in > 7'h46) [*3] |-> ##[1:4] !pump_enable_out)
    else $error("delivery not stopped on overpressure");
  chk_no_stroke: assert property (stroke_req_out |-> $past(fault_num_out) == 3'h0)
    else $error("stroke requested while a fault or notice is active");
  chk_fault_screen: assert property ((fault_num_out >= 3'h2 && screen_out != 2'h3) [*3] |-> screen_out == 2'h1)
    else $error("fault screen not shown");
  chk_high_ok: assert property ($fell(status_out) |-> fault_num_out != 3'h0 || $past(fault_num_out) != 3'h0)
    else $error("status line fell with no fault or notice");
  chk_wave_half: assert property ((status_out != prev) && armed && fault_num_out == 3'h1 |-> run == HALF - 1)
    else $error("empty wave half period wrong");
  chk_fill_shown: assert property ((low_fill_out && fault_num_out == 3'h0 && screen_out != 2'h3) [*3] |-> screen_out == 2'h2)
    else $error("fill percent not shown under low fill");
  chk_low_pct: assert property ($rose(low_fill_out) |-> ##[0:40] fill_pct_out < 7'h1C)
    else $error("low fill raised above threshold");
  chk_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus access not answered after one wait state");
  chk_bus_single: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  cov_wave: cover property (armed && status_out != prev);
  cov_stroke: cover property (stroke_req_out);
  cov_low: cover property ($rose(low_fill_out));
endmodule // lfs_top_asserts
bind lfs_top lfs_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .pressure_bar_in(pressure_bar_in),
  .supply_bad_in(supply_bad_in), .status_out(status_out), .pump_enable_out(pump_enable_out),
  .stroke_req_out(stroke_req_out), .screen_out(screen_out), .fault_num_out(fault_num_out),
  .fill_pct_out(fill_pct_out), .low_fill_out(low_fill_out));
`default_nettype wire

// >>> verification/lfs_plc_model.sv
// controller model on the far side: drives the command line, reads the status line
// assumes one command at a time, called from the bench's main process
`timescale 1ns/1ns
`default_nettype none
module lfs_plc_model #(
  parameter MS_CYCLES = 10
) (
  input  wire logic mclk_in,
  input  wire logic status_in,
  output var  logic cmd_out
);
  logic last_status; // answer level read after the last command
  initial cmd_out = 1'b0;
  // a high pulse of whole ms, then wait and read back the answer before returning
  task automatic send(input int ms);
    @(posedge mclk_in);
    cmd_out <= 1'b1;
    repeat (ms * MS_CYCLES) @(posedge mclk_in);
    cmd_out <= 1'b0;
    repeat (8) @(posedge mclk_in);
    last_status = status_in;
  endtask
endmodule // lfs_plc_model
`default_nettype wire

// >>> verification/test_lubricator_fault_status_signaling.sv
// bench for the fault and status block: bus, fault inputs, command line
// assumes the checker binds itself; 1 ms is scaled to MS clock cycles
`timescale 1ns/1ns
`default_nettype none
module test_lubricator_fault_status_signaling;
  localparam int MS = 10;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        ce      = 1'b1;
  logic [4:0]  adr     = 5'h00;
  logic        rd_en   = 1'b0;
  logic        wr_en   = 1'b0;
  logic [31:0] wdat    = 32'h0;
  logic [6:0]  press   = 7'h00;
  logic        sup     = 1'b0;
  logic        intl    = 1'b0;
  logic        sdone   = 1'b0;
  logic [2:0]  pl      = 3'h0;
  logic [31:0] seed    = 32'hB0E4DDD0;
  logic [31:0] rdat;
  logic        wreq, status, pump, sreq, lowf, cmd, prev_st;
  logic [6:0]  pct;
  logic [1:0]  scr;
  logic [2:0]  fnum;
  logic [31:0] rq[$];
  logic [6:0]  sq[$];
  bit          kq[$];
  int          cq[$];
  int          failures = 0;
  int          checks_done = 0;
  int          toggles = 0;
  event        snap_ev, cnt_ev;
  always #5 mclk_in = ~mclk_in;
  lfs_top #(.MS_CYCLES(MS)) dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(adr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdat),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .pressure_bar_in(press),
    .supply_bad_in(sup), .internal_bad_in(intl), .stroke_done_in(sdone),
    .local_ack_in(pl[0]), .selftest_in(pl[1]), .cartridge_new_in(pl[2]), .cmd_in(cmd),
    .status_out(status), .pump_enable_out(pump), .stroke_req_out(sreq), .screen_out(scr),
    .fault_num_out(fnum), .fill_pct_out(pct), .low_fill_out(lowf));
  lfs_plc_model #(.MS_CYCLES(MS)) plc (.mclk_in(mclk_in), .status_in(status), .cmd_out(cmd));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // one bus access, held until waitrequest is sampled low, then released
  // no cycle limit here: only the watchdog ends a wait that never gets an answer
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    adr   <= a;
    wdat  <= d;
    rd_en <= !w;
    wr_en <= w;
    do begin
      @(posedge mclk_in);
    end while (wreq !== 1'b0);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // port levels {status, pump, screen, fault number}, sampled once settled
  task automatic snap(input logic [6:0] e);
    hold(4);
    @(negedge mclk_in);
    sq.push_back(e);
    -> snap_ev;
    @(posedge mclk_in);
  endtask
  task automatic pls(input logic [2:0] m);
    @(posedge mclk_in);
    pl <= m;
    @(posedge mclk_in);
    pl <= 3'h0;
  endtask
  task automatic strokes(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      sdone <= 1'b1;
      @(posedge mclk_in);
      sdone <= 1'b0;
    end
  endtask
  task automatic fault(input logic s);
    sup  <= s;
    intl <= !s;
    hold(4);
    sup  <= 1'b0;
    intl <= 1'b0;
  endtask
  // ******************************************************************
  // monitor: takes the oldest note whenever a result appears
  // ******************************************************************
  always @(posedge mclk_in) begin
    prev_st <= status;
    if (!rst_in && status !== prev_st)
      toggles <= toggles + 1;
    if (rd_en && wreq === 1'b0)
      check("readdata", rdat, rq.pop_front());
    if (sreq === 1'b1) begin
      check("stroke request", {31'h0, kq.size() != 0}, 32'h1);
      if (kq.size() != 0)
        void'(kq.pop_front());
    end
  end
  always @(snap_ev) check("port levels", {25'h0, status, pump, scr, fnum}, {25'h0, sq.pop_front()});
  always @(cnt_ev) check("status toggles", 32'(toggles), 32'(cq.pop_front()));
  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    int t0;
    hold(12);
    rst_in <= 1'b0;
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h0E10);
    rd(5'h0C, 32'h0320);
    // strokes reported while the clock enable is low must not be counted
    ce <= 1'b0;
    strokes(3);
    ce <= 1'b1;
    bus(1'b1, 5'h10, 32'h5);
    rd(5'h10, 32'h0);
    rd(5'h18, 32'h0);
    bus(1'b1, 5'h08, 32'h7);
    rd(5'h08, 32'h7);
    hold(5100);
    snap(7'h60);
    plc.send(90);
    rd(5'h14, 32'h6400);
    fault(1'b1);
    snap(7'h0B);
    pls(3'h1);
    snap(7'h60);
    press <= 7'h46;
    snap(7'h60);
    seed = lfsr(seed);
    press <= 7'h47 + 7'(seed % 57);
    hold(4);
    seed = lfsr(seed);
    press <= 7'(seed % 71);
    pls(3'h1);
    snap(7'h0A);
    pls(3'h2);
    hold(5100);
    snap(7'h60);
    bus(1'b1, 5'h00, 32'h2);
    fault(1'b0);
    pls(3'h1);
    snap(7'h0C);
    plc.send(500);
    check("plc answer", {31'h0, plc.last_status}, 32'h0);
    rd(5'h14, 32'h6428);
    plc.send(1710);
    check("plc answer", {31'h0, plc.last_status}, 32'h1);
    snap(7'h60);
    kq.push_back(1'b1);
    plc.send(110);
    strokes(1);
    rd(5'h10, 32'h1);
    bus(1'b1, 5'h0C, 32'h32);
    pls(3'h4);
    // the percent divider restarts only every third ms tick, so allow two runs
    strokes(41);
    hold(70);
    rd(5'h14, 32'h1200);
    strokes(1);
    hold(70);
    rd(5'h14, 32'h1010);
    snap(7'h70);
    pls(3'h4);
    strokes(37);
    bus(1'b1, 5'h00, 32'h6);
    hold(70);
    rd(5'h14, 32'h1A10);
    bus(1'b1, 5'h00, 32'h2);
    hold(70);
    rd(5'h14, 32'h1A00);
    bus(1'b1, 5'h00, 32'h0);
    strokes(13);
    hold(70);
    rd(5'h14, 32'h0011);
    t0 = toggles;
    hold(2000 * MS);
    cq.push_back(t0 + 2);
    -> cnt_ev;
    fault(1'b1);
    snap(7'h0B);
    pls(3'h1);
    pls(3'h4);
    snap(7'h60);
    bus(1'b1, 5'h00, 32'h8);
    snap(7'h40);
    check("notes left", 32'(rq.size() + sq.size() + kq.size() + cq.size()), 32'h0);
    summarize;
  end
  // watchdog: the sequence needs about 55000 cycles
  initial begin
    hold(95000);
    failures++;
    summarize;
  end
endmodule // test_lubricator_fault_status_signaling
`default_nettype wire
